// ==== hdl/dcp_regs.svh ====
// register offsets, field positions and reset values of the dma cell channel
`ifndef DCP_REGS_SVH
`define DCP_REGS_SVH

`define DCP_ADDR_W        8
`define DCP_DATA_W        32
`define DCP_SIZE_W        16
`define DCP_PAT_W         8
`define DCP_MODE_W        2
`define DCP_LVL_W         8

`define DCP_OFF_CTRL      8'h00
`define DCP_OFF_STATUS    8'h04
`define DCP_OFF_SIZE      8'h08
`define DCP_OFF_PTR       8'h0C
`define DCP_OFF_PAT       8'h10

`define DCP_CTRL_EN_BIT   0
`define DCP_CTRL_MODE_LSB 1
`define DCP_CTRL_MODE_MSB 2

`define DCP_ST_BUSY_BIT   0
`define DCP_ST_DONE_BIT   1
`define DCP_ST_TERM_BIT   2
`define DCP_ST_OVR_BIT    3
`define DCP_ST_LVL_LSB    8
`define DCP_ST_LVL_MSB    15

`define DCP_SIZE_RST      16'h0000
`define DCP_PTR_RST       16'h0000
`define DCP_PTR_ONE       16'h0001
`define DCP_PAT_RST       8'h00
`define DCP_RDATA_RST     32'h0000_0000

`endif

// ==== hdl/dcp_pkg.sv ====
// types shared by the dma cell channel modules
package dcp_pkg;

  typedef enum logic [1:0] {
    DCP_MODE_BASIC  = 2'h0,
    DCP_MODE_DETECT = 2'h1,
    DCP_MODE_TERM   = 2'h2,
    DCP_MODE_RSVD   = 2'h3
  } dcp_mode_t;

  typedef enum logic [1:0] {
    DCP_ST_IDLE = 2'h1,
    DCP_ST_MOVE = 2'h2
  } dcp_state_t;

endpackage

// ==== hdl/dcp_fifo.sv ====
// synchronous fifo with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none

module dcp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32
) (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               ce,
  input  wire logic [WIDTH-1:0]   in_data,
  input  wire logic               in_valid,
  output logic                    in_ready,
  output logic [WIDTH-1:0]        out_data,
  output logic                    out_valid,
  input  wire logic               out_ready,
  output logic [$clog2(DEPTH):0]  level
);

  localparam int AW = $clog2(DEPTH);

  initial begin
    if (DEPTH < 4 || (1 << AW) != DEPTH || WIDTH < 1) begin
      $error("dcp_fifo: depth must be a power of two of at least 4");
    end
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    wptr_next;
  logic [AW-1:0]    rptr_reg;
  logic [AW-1:0]    rptr_next;
  logic [AW:0]      cnt_reg;
  logic [AW:0]      cnt_next;
  logic             push;
  logic             pop;

  assign in_ready  = (cnt_reg != DEPTH[AW:0]);
  assign out_valid = (cnt_reg != '0);
  assign out_data  = mem[rptr_reg];
  assign level     = cnt_reg;

  always_comb begin
    push      = in_valid & in_ready;
    pop       = out_valid & out_ready;
    wptr_next = push ? wptr_reg + 1'b1 : wptr_reg;
    rptr_next = pop ? rptr_reg + 1'b1 : rptr_reg;
    cnt_next  = cnt_reg;
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (ce && push) begin
      mem[wptr_reg] <= in_data;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg  <= '0;
    end else if (ce) begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg  <= cnt_next;
    end
  end

endmodule // dcp_fifo

`default_nettype wire

// ==== hdl/dcp_match.sv ====
// byte comparator that ends a cell on a matching byte
`timescale 1ns/1ps
`default_nettype none
`include "dcp_regs.svh"

module dcp_match (
  input  wire logic                  enable,
  input  wire logic                  strobe,
  input  wire logic [`DCP_PAT_W-1:0] data,
  input  wire logic [`DCP_PAT_W-1:0] pattern,
  output logic                       hit
);

  // pattern only counts while enabled
  assign hit = enable & strobe & (data == pattern); // [R05]

endmodule // dcp_match

`default_nettype wire

// ==== hdl/dcp_channel.sv ====
// dma channel cell size, cell pointer and pattern data with byte stream path
//
// Operation
// [R01] each trigger moves as many bytes as the 16-bit cell size field holds, all ones = 65535.
// [R02] bits 31 to 16 of cell size and cell pointer read as zero.
// [R03] in pattern detect mode a pattern detect resets the cell pointer.
// [R04] software loads the match byte into bits 7 to 0 of pattern data before terminate mode.
// [R05] outside pattern terminate mode the pattern data has no effect.
// [R06] bits 31 to 8 of pattern data read as zero.
// [R07] the cell pointer is read-only, counts bytes of the cell and returns to zero at cell end.
`timescale 1ns/1ps
`default_nettype none
`include "dcp_regs.svh"

module dcp_channel #(
  parameter int FIFO_DEPTH = 32
) (
  input  wire logic                   core_clk,
  input  wire logic                   rst_n,
  input  wire logic                   ce,
  input  wire logic [`DCP_ADDR_W-1:0] reg_addr,
  input  wire logic [`DCP_DATA_W-1:0] reg_wdata,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  output logic      [`DCP_DATA_W-1:0] reg_rdata,
  input  wire logic                   trig,
  input  wire logic                   pat_detect,
  input  wire logic [`DCP_PAT_W-1:0]  src_data,
  input  wire logic                   src_valid,
  output logic                        src_ready,
  output logic      [`DCP_PAT_W-1:0]  dst_data,
  output logic                        dst_valid,
  input  wire logic                   dst_ready,
  output logic                        busy,
  output logic                        cell_done
);

  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  initial begin
    if (FIFO_DEPTH < 4 || FIFO_DEPTH > 128) begin
      $error("dcp_channel: fifo depth must lie between 4 and 128");
    end
  end

  // registers
  logic                   ctrl_en_reg;
  logic                   ctrl_en_next;
  dcp_pkg::dcp_mode_t     ctrl_mode_reg;
  dcp_pkg::dcp_mode_t     ctrl_mode_next;
  logic [`DCP_SIZE_W-1:0] size_reg;
  logic [`DCP_SIZE_W-1:0] size_next;
  logic [`DCP_SIZE_W-1:0] ptr_reg;
  logic [`DCP_SIZE_W-1:0] ptr_next;
  logic [`DCP_PAT_W-1:0]  pat_reg;
  logic [`DCP_PAT_W-1:0]  pat_next;
  logic                   done_reg;
  logic                   done_next;
  logic                   term_reg;
  logic                   term_next;
  logic                   ovr_reg;
  logic                   ovr_next;
  logic [`DCP_DATA_W-1:0] rdata_reg;
  logic [`DCP_DATA_W-1:0] rdata_next;

  // channel state
  dcp_pkg::dcp_state_t    state_reg;
  dcp_pkg::dcp_state_t    state_next;
  logic                   src_ready_reg;
  logic                   src_ready_next;
  logic                   cell_done_reg;
  logic                   cell_done_next;
  logic                   busy_reg;
  logic                   busy_next;

  // output stage
  logic [`DCP_PAT_W-1:0]  dst_data_reg;
  logic [`DCP_PAT_W-1:0]  dst_data_next;
  logic                   dst_valid_reg;
  logic                   dst_valid_next;

  // internal
  logic                   fifo_in_ready;
  logic [`DCP_PAT_W-1:0]  fifo_out_data;
  logic                   fifo_out_valid;
  logic                   fifo_pop;
  logic [LW-1:0]          fifo_level;
  logic                   accept;
  logic                   match_hit;
  logic                   last_byte;
  logic                   end_cell;
  logic                   det_clear;
  logic                   wr_ctrl;
  logic                   wr_status;
  logic                   wr_size;
  logic                   wr_pat;
  logic                   room;
  logic                   term_mode;
  logic [`DCP_LVL_W-1:0]  lvl_ext;

  assign reg_rdata = rdata_reg;
  assign src_ready = src_ready_reg;
  assign dst_data  = dst_data_reg;
  assign dst_valid = dst_valid_reg;
  assign busy      = busy_reg;
  assign cell_done = cell_done_reg;

  dcp_fifo #(
    .WIDTH (`DCP_PAT_W),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .ce        (ce),
    .in_data   (src_data),
    .in_valid  (accept),
    .in_ready  (fifo_in_ready),
    .out_data  (fifo_out_data),
    .out_valid (fifo_out_valid),
    .out_ready (fifo_pop),
    .level     (fifo_level)
  );

  dcp_match u_match (
    .enable  (term_mode),
    .strobe  (accept),
    .data    (src_data),
    .pattern (pat_reg),
    .hit     (match_hit)
  );

  always_comb begin
    term_mode = (ctrl_mode_reg == dcp_pkg::DCP_MODE_TERM); // [R05]
    accept    = src_valid & src_ready_reg & fifo_in_ready;
    last_byte = (ptr_reg == (size_reg - `DCP_PTR_ONE)); // [R01]
    end_cell  = accept & (last_byte | match_hit);
    det_clear = (ctrl_mode_reg == dcp_pkg::DCP_MODE_DETECT) & pat_detect; // [R03]
    room      = (fifo_level <= LW'(FIFO_DEPTH - 2));
    lvl_ext   = `DCP_LVL_W'(fifo_level);
    wr_ctrl   = reg_wr & (reg_addr == `DCP_OFF_CTRL);
    wr_status = reg_wr & (reg_addr == `DCP_OFF_STATUS);
    wr_size   = reg_wr & (reg_addr == `DCP_OFF_SIZE);
    wr_pat    = reg_wr & (reg_addr == `DCP_OFF_PAT);
  end

  // register file writes
  always_comb begin
    ctrl_en_next   = ctrl_en_reg;
    ctrl_mode_next = ctrl_mode_reg;
    size_next      = size_reg;
    pat_next       = pat_reg;
    if (wr_ctrl) begin
      ctrl_en_next   = reg_wdata[`DCP_CTRL_EN_BIT];
      ctrl_mode_next = dcp_pkg::dcp_mode_t'(reg_wdata[`DCP_CTRL_MODE_MSB:`DCP_CTRL_MODE_LSB]);
    end
    if (wr_size) begin
      size_next = reg_wdata[`DCP_SIZE_W-1:0]; // [R01]
    end
    if (wr_pat) begin
      pat_next = reg_wdata[`DCP_PAT_W-1:0]; // [R04]
    end
  end

  // channel sequencing, pointer and sticky flags
  always_comb begin
    state_next     = state_reg;
    ptr_next       = ptr_reg;
    done_next      = done_reg;
    term_next      = term_reg;
    ovr_next       = ovr_reg;
    cell_done_next = 1'b0;
    // write one to clear, set below wins
    if (wr_status) begin
      if (reg_wdata[`DCP_ST_DONE_BIT]) begin
        done_next = 1'b0;
      end
      if (reg_wdata[`DCP_ST_TERM_BIT]) begin
        term_next = 1'b0;
      end
      if (reg_wdata[`DCP_ST_OVR_BIT]) begin
        ovr_next = 1'b0;
      end
    end
    case (state_reg)
      dcp_pkg::DCP_ST_IDLE: begin
        ptr_next = `DCP_PTR_RST;
        if (trig && ctrl_en_reg) begin
          if (size_reg == `DCP_SIZE_RST) begin
            done_next      = 1'b1;
            cell_done_next = 1'b1;
          end else begin
            state_next = dcp_pkg::DCP_ST_MOVE; // [R01]
          end
        end
      end
      dcp_pkg::DCP_ST_MOVE: begin
        if (trig) begin
          ovr_next = 1'b1;
        end
        if (!ctrl_en_reg) begin
          state_next = dcp_pkg::DCP_ST_IDLE;
          ptr_next   = `DCP_PTR_RST;
        end else if (end_cell) begin
          state_next     = dcp_pkg::DCP_ST_IDLE;
          ptr_next       = `DCP_PTR_RST; // [R07]
          done_next      = 1'b1;
          cell_done_next = 1'b1;
          if (match_hit) begin
            term_next = 1'b1;
          end
        end else if (accept) begin
          ptr_next = ptr_reg + `DCP_PTR_ONE; // [R07]
        end
      end
      default: begin
        state_next = dcp_pkg::DCP_ST_IDLE;
        ptr_next   = `DCP_PTR_RST;
      end
    endcase
    if (det_clear) begin
      ptr_next = `DCP_PTR_RST; // [R03]
    end
    busy_next      = (state_next == dcp_pkg::DCP_ST_MOVE);
    src_ready_next = busy_next & room;
  end

  // output stage fed from the fifo
  always_comb begin
    fifo_pop       = fifo_out_valid & (~dst_valid_reg | dst_ready);
    dst_valid_next = dst_valid_reg;
    dst_data_next  = dst_data_reg;
    if (fifo_pop) begin
      dst_valid_next = 1'b1;
      dst_data_next  = fifo_out_data;
    end else if (dst_ready) begin
      dst_valid_next = 1'b0;
    end
  end

  // read data, one cycle after the strobe
  always_comb begin
    rdata_next = `DCP_RDATA_RST;
    if (reg_rd) begin
      case (reg_addr)
        `DCP_OFF_CTRL: begin
          rdata_next[`DCP_CTRL_EN_BIT] = ctrl_en_reg;
          rdata_next[`DCP_CTRL_MODE_MSB:`DCP_CTRL_MODE_LSB] = ctrl_mode_reg;
        end
        `DCP_OFF_STATUS: begin
          rdata_next[`DCP_ST_BUSY_BIT] = busy_reg;
          rdata_next[`DCP_ST_DONE_BIT] = done_reg;
          rdata_next[`DCP_ST_TERM_BIT] = term_reg;
          rdata_next[`DCP_ST_OVR_BIT]  = ovr_reg;
          rdata_next[`DCP_ST_LVL_MSB:`DCP_ST_LVL_LSB] = lvl_ext;
        end
        `DCP_OFF_SIZE: begin
          rdata_next[`DCP_SIZE_W-1:0] = size_reg; // [R02]
        end
        `DCP_OFF_PTR: begin
          rdata_next[`DCP_SIZE_W-1:0] = ptr_reg; // [R02]
        end
        `DCP_OFF_PAT: begin
          rdata_next[`DCP_PAT_W-1:0] = pat_reg; // [R06]
        end
        default: begin
          rdata_next = `DCP_RDATA_RST;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_en_reg   <= 1'b0;
      ctrl_mode_reg <= dcp_pkg::DCP_MODE_BASIC;
      size_reg      <= `DCP_SIZE_RST;
      ptr_reg       <= `DCP_PTR_RST;
      pat_reg       <= `DCP_PAT_RST;
      done_reg      <= 1'b0;
      term_reg      <= 1'b0;
      ovr_reg       <= 1'b0;
      rdata_reg     <= `DCP_RDATA_RST;
      state_reg     <= dcp_pkg::DCP_ST_IDLE;
      src_ready_reg <= 1'b0;
      cell_done_reg <= 1'b0;
      busy_reg      <= 1'b0;
      dst_data_reg  <= `DCP_PAT_RST;
      dst_valid_reg <= 1'b0;
    end else if (ce) begin
      ctrl_en_reg   <= ctrl_en_next;
      ctrl_mode_reg <= ctrl_mode_next;
      size_reg      <= size_next;
      ptr_reg       <= ptr_next;
      pat_reg       <= pat_next;
      done_reg      <= done_next;
      term_reg      <= term_next;
      ovr_reg       <= ovr_next;
      rdata_reg     <= rdata_next;
      state_reg     <= state_next;
      src_ready_reg <= src_ready_next;
      cell_done_reg <= cell_done_next;
      busy_reg      <= busy_next;
      dst_data_reg  <= dst_data_next;
      dst_valid_reg <= dst_valid_next;
    end
  end

endmodule // dcp_channel

`default_nettype wire

// ==== sim/dcp_channel_monitor.sv ====
// concurrent checks on the dma cell channel ports
`timescale 1ns/1ps
`default_nettype none
`include "dcp_regs.svh"

module dcp_channel_monitor #(
  parameter int FIFO_DEPTH = 32
) (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        ce,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        trig,
  input wire logic        pat_detect,
  input wire logic [7:0]  src_data,
  input wire logic        src_valid,
  input wire logic        src_ready,
  input wire logic [7:0]  dst_data,
  input wire logic        dst_valid,
  input wire logic        dst_ready,
  input wire logic        busy,
  input wire logic        cell_done
);
  logic [15:0] size_reg;
  logic [15:0] cnt_reg;
  logic [1:0]  mode_reg;

  // shadow of size and mode, bytes taken in this cell
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      size_reg <= 16'h0000;
      cnt_reg  <= 16'h0000;
      mode_reg <= 2'h0;
    end else if (ce) begin
      if (reg_wr && reg_addr == `DCP_OFF_SIZE) size_reg <= reg_wdata[15:0];
      if (reg_wr && reg_addr == `DCP_OFF_CTRL) mode_reg <= reg_wdata[2:1];
      cnt_reg <= busy ? cnt_reg + 16'(src_valid && src_ready) : 16'h0000;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_rdata_idle: assert property (ce && !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside a read");
  a_size_ptr_upper: assert property (ce && reg_rd && (reg_addr == `DCP_OFF_SIZE ||
    reg_addr == `DCP_OFF_PTR) |=> reg_rdata[31:16] == 16'h0000)
    else $error("upper half of size or pointer not zero");
  a_pat_upper_zero: assert property (ce && reg_rd && reg_addr == `DCP_OFF_PAT
    |=> reg_rdata[31:8] == 24'h00_0000)
    else $error("upper bits of pattern data not zero");
  a_ptr_idle_zero: assert property (ce && reg_rd && reg_addr == `DCP_OFF_PTR && !busy
    |=> reg_rdata == 32'h0000_0000)
    else $error("pointer not zero while idle");
  a_ready_needs_busy: assert property (src_ready |-> busy)
    else $error("input ready outside a cell");
  a_done_one_cycle: assert property (ce && cell_done && !trig |=> !cell_done && !busy)
    else $error("cell done longer than one cycle");
  a_busy_from_trig: assert property ($rose(busy) |-> $past(trig))
    else $error("cell started without a trigger");
  a_dst_hold: assert property (ce && dst_valid && !dst_ready |=> dst_valid && $stable(dst_data))
    else $error("output byte dropped before taken");
  a_cell_byte_count: assert property (cell_done && mode_reg != 2'h1 && mode_reg != 2'h2
    && size_reg != 16'h0000 |-> cnt_reg == size_reg)
    else $error("bytes in cell differ from cell size");

  c_term_end: cover property (cell_done && mode_reg == 2'h2);
  c_detect_busy: cover property (pat_detect && busy);
  c_input_refused: cover property (src_valid && !src_ready && busy);
endmodule // dcp_channel_monitor

bind dcp_channel dcp_channel_monitor #(.FIFO_DEPTH(FIFO_DEPTH)) i_dcp_channel_monitor (
  .core_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trig,
  .pat_detect, .src_data, .src_valid, .src_ready, .dst_data, .dst_valid, .dst_ready,
  .busy, .cell_done);
`default_nettype wire

// ==== sim/testbench.sv ====
// self-checking bench for the dma cell channel
`timescale 1ns/1ps
`default_nettype none
`include "dcp_regs.svh"

module testbench;
  logic        core_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        ce = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        trig = 1'b0;
  logic        pat_detect = 1'b0;
  logic [7:0]  src_data = 8'h00;
  logic        src_valid = 1'b0;
  logic        dst_ready = 1'b0;
  logic        stall = 1'b0;
  logic [31:0] reg_rdata;
  logic [7:0]  dst_data;
  logic        src_ready, dst_valid, busy, cell_done;
  logic [7:0]  sent[$];
  logic [7:0]  got[$];
  int          n_errors = 0;
  int          checks_done = 0;
  int          base;

  always #12.5 core_clk = ~core_clk;

  dcp_channel i_dcp_channel (
    .core_clk, .rst_n, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .trig,
    .pat_detect, .src_data, .src_valid, .src_ready, .dst_data, .dst_valid, .dst_ready,
    .busy, .cell_done);

  // record both streams, sink stalls every other cycle, and every cycle while stall is set
  always @(posedge core_clk) begin
    if (src_valid && src_ready) sent.push_back(src_data);
    if (dst_valid && dst_ready) got.push_back(dst_data);
    dst_ready <= !stall && !dst_ready;
  end

  task automatic close_out();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
    checks_done++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic hang(input string m);
    n_errors++;
    $display("[ERR] %0t %s", $time, m);
    close_out();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    @(negedge core_clk);
    chk(reg_rdata, e, m);
    @(posedge core_clk);
  endtask

  task automatic pulse(input bit det);
    if (det) pat_detect <= 1'b1;
    else trig <= 1'b1;
    @(posedge core_clk);
    trig <= 1'b0;
    pat_detect <= 1'b0;
  endtask

  task automatic send(input int n, input logic [7:0] d);
    int   k;
    logic t;
    src_data <= d;
    src_valid <= 1'b1;
    for (k = 0; n > 0 && k < 300; k++) begin
      @(negedge core_clk);
      t = (src_ready === 1'b1);
      if (t) n--;
      @(posedge core_clk);
      if (t && n > 0) src_data <= src_data + 8'h01;
    end
    src_valid <= 1'b0;
    if (n > 0) hang("input stream stalled");
  endtask

  task automatic wait_done();
    int k;
    for (k = 0; k < 300 && cell_done !== 1'b1; k++) @(negedge core_clk);
    if (k >= 300) begin
      hang("cell never ended");
    end else begin
      @(posedge core_clk);
    end
  endtask

  initial begin
    repeat (6) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    rd(`DCP_OFF_SIZE, 32'h0000_0000, "size reset");
    rd(`DCP_OFF_PTR, 32'h0000_0000, "pointer reset");
    rd(`DCP_OFF_PAT, 32'h0000_0000, "pattern reset");
    wr(`DCP_OFF_SIZE, 32'hFFFF_FFFF);
    rd(`DCP_OFF_SIZE, 32'h0000_FFFF, "size all ones");
    wr(`DCP_OFF_PAT, 32'hFFFF_FF5A);
    rd(`DCP_OFF_PAT, 32'h0000_005A, "pattern byte");
    wr(`DCP_OFF_PTR, 32'h0000_0007);
    rd(`DCP_OFF_PTR, 32'h0000_0000, "pointer write");
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000, "unmapped read");
    wr(`DCP_OFF_SIZE, 32'h0000_0003);
    pulse(0);
    @(negedge core_clk);
    chk(busy, 32'h0, "trigger while disabled");
    $display("test registers done");
    wr(`DCP_OFF_CTRL, 32'h0000_0001);
    pulse(0);
    send(1, 8'h59);
    rd(`DCP_OFF_PTR, 32'h0000_0001, "pointer mid cell");
    pulse(1);
    rd(`DCP_OFF_PTR, 32'h0000_0001, "detect in basic mode");
    send(2, 8'h5A);
    wait_done();
    rd(`DCP_OFF_PTR, 32'h0000_0000, "pointer after cell");
    $display("test basic done");
    wr(`DCP_OFF_CTRL, 32'h0000_0003);
    wr(`DCP_OFF_SIZE, 32'h0000_0004);
    base = sent.size();
    pulse(0);
    send(2, 8'h5A);
    rd(`DCP_OFF_PTR, 32'h0000_0002, "pointer before detect");
    pulse(1);
    rd(`DCP_OFF_PTR, 32'h0000_0000, "pointer after detect");
    send(4, 8'h5A);
    wait_done();
    chk(sent.size() - base, 32'd6, "bytes in detect cell");
    $display("test detect done");
    wr(`DCP_OFF_CTRL, 32'h0000_0005);
    wr(`DCP_OFF_SIZE, 32'h0000_0008);
    base = sent.size();
    pulse(0);
    send(3, 8'h58);
    wait_done();
    chk(sent.size() - base, 32'd3, "bytes in terminate cell");
    repeat (10) @(posedge core_clk);
    rd(`DCP_OFF_STATUS, 32'h0000_0006, "done and match flags");
    wr(`DCP_OFF_STATUS, 32'h0000_000E);
    rd(`DCP_OFF_STATUS, 32'h0000_0000, "flags cleared");
    wr(`DCP_OFF_SIZE, 32'h0000_0000);
    ce <= 1'b0;
    pulse(0);
    @(negedge core_clk);
    chk(cell_done, 32'h0, "trigger while frozen");
    @(posedge core_clk);
    ce <= 1'b1;
    pulse(0);
    wait_done();
    $display("test terminate done");
    wr(`DCP_OFF_CTRL, 32'h0000_0001);
    wr(`DCP_OFF_SIZE, 32'h0000_0028);
    base = sent.size();
    stall <= 1'b1;
    pulse(0);
    src_data <= 8'h01;
    src_valid <= 1'b1;
    repeat (60) @(posedge core_clk);
    pulse(0);
    @(negedge core_clk);
    chk(src_ready, 32'h0, "full buffer refuses");
    @(posedge core_clk);
    rd(`DCP_OFF_STATUS, 32'h0000_200B, "overrun and level");
    stall <= 1'b0;
    send(40 - (sent.size() - base), 8'h01);
    wait_done();
    repeat (100) @(posedge core_clk);
    chk(got.size(), sent.size(), "bytes drained");
    for (base = 0; base < sent.size() && base < got.size(); base++) begin
      chk(got[base], sent[base], "byte order");
    end
    $display("test buffer done");
    close_out();
  end
endmodule // testbench
`default_nettype wire
